// [remap_regs_pkg.sv]
// register map, field constants and carrier types of the remapping register bank
package remap_regs_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W = 10;
	localparam int unsigned PAGE_BYTES = 4096;

	// byte offsets inside the 4KB page
	localparam logic [11:0] ADDR_VERSION = 12'h000;
	localparam logic [11:0] ADDR_CAP = 12'h008;
	localparam logic [11:0] ADDR_ECAP = 12'h010;
	localparam logic [11:0] ADDR_GLOBAL_COMMAND = 12'h018;
	localparam logic [11:0] ADDR_GLOBAL_STATE = 12'h01c;
	localparam logic [11:0] ADDR_ROOT_TABLE_BASE = 12'h020;
	localparam logic [11:0] ADDR_CONTEXT_CACHE_COMMAND = 12'h028;
	localparam logic [11:0] ADDR_FAULT_STATE = 12'h034;
	localparam logic [11:0] ADDR_FAULT_EVENT_CONTROL = 12'h038;
	localparam logic [11:0] ADDR_FAULT_EVENT_MSG_DATA = 12'h03c;
	localparam logic [11:0] ADDR_FAULT_EVENT_MSG_ADDR = 12'h040;
	localparam logic [11:0] ADDR_FAULT_EVENT_MSG_UPPER_ADDR = 12'h044;
	localparam logic [11:0] ADDR_ADVANCED_FAULT_LOG = 12'h058;
	localparam logic [11:0] ADDR_PROTECTED_REGION_ENABLE = 12'h064;
	localparam logic [11:0] ADDR_PROTECTED_LOW_BASE = 12'h068;
	localparam logic [11:0] ADDR_PROTECTED_LOW_LIMIT = 12'h06c;
	localparam logic [11:0] ADDR_PROTECTED_HIGH_BASE = 12'h070;
	localparam logic [11:0] ADDR_PROTECTED_HIGH_LIMIT = 12'h078;
	localparam logic [11:0] ADDR_INVAL_QUEUE_HEAD = 12'h080;
	localparam logic [11:0] ADDR_INVAL_QUEUE_TAIL = 12'h088;
	localparam logic [11:0] ADDR_INVAL_QUEUE_BASE = 12'h090;
	localparam logic [11:0] ADDR_INVAL_COMPLETION_STATE = 12'h09c;
	localparam logic [11:0] ADDR_INVAL_EVENT_CONTROL = 12'h0a0;
	localparam logic [11:0] ADDR_INVAL_EVENT_MSG_DATA = 12'h0a4;
	localparam logic [11:0] ADDR_INVAL_EVENT_MSG_ADDR = 12'h0a8;
	localparam logic [11:0] ADDR_INVAL_EVENT_MSG_UPPER_ADDR = 12'h0ac;
	localparam logic [11:0] ADDR_IRQ_REMAP_TABLE_BASE = 12'h0b8;
	localparam logic [11:0] ADDR_TRANSLATION_CACHE_INVAL = 12'h100;
	localparam logic [11:0] ADDR_FAULT_RECORD = 12'h200;

	// version fields
	localparam int unsigned VER_MAJOR_LSB = 4;
	localparam int unsigned VER_MINOR_LSB = 0;
	localparam logic [3:0] VER_MAJOR = 4'h1;
	localparam logic [3:0] VER_MINOR = 4'h0;
	localparam logic [31:0] VERSION_VALUE = {24'h000000, VER_MAJOR, VER_MINOR};

	// capability reporting; fault record offset in 16-byte units
	localparam int unsigned CAP_FRO_LSB = 24;
	localparam logic [9:0] CAP_FRO = 10'(ADDR_FAULT_RECORD / 16);
	localparam logic [63:0] CAP_OTHER = 64'h0000000000000000;
	localparam logic [63:0] CAP_VALUE = CAP_OTHER | (64'(CAP_FRO) << CAP_FRO_LSB);
	localparam logic [63:0] ECAP_VALUE = 64'h0000000000000000;

	typedef enum logic [3:0] {
		KIND_RW = 4'h1,
		KIND_W1C = 4'h2,
		KIND_W1CS = 4'h4,
		KIND_ROS = 4'h8
	} cell_kind_t;

	// stored dwords
	localparam int unsigned NSLOT = 38;
	localparam logic [11:0] SLOT_ADDR [NSLOT] = '{
		12'h018, 12'h020, 12'h024, 12'h028, 12'h02c, 12'h034, 12'h038, 12'h03c,
		12'h040, 12'h044, 12'h058, 12'h05c, 12'h064, 12'h068, 12'h06c, 12'h070,
		12'h074, 12'h078, 12'h07c, 12'h088, 12'h08c, 12'h090, 12'h094, 12'h09c,
		12'h0a0, 12'h0a4, 12'h0a8, 12'h0ac, 12'h0b8, 12'h0bc, 12'h100, 12'h104,
		12'h108, 12'h10c, 12'h200, 12'h204, 12'h208, 12'h20c
	};
	localparam cell_kind_t SLOT_KIND [NSLOT] = '{
		KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_W1CS, KIND_RW, KIND_RW,
		KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW,
		KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_W1C,
		KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW, KIND_RW,
		KIND_RW, KIND_RW, KIND_ROS, KIND_ROS, KIND_ROS, KIND_W1CS
	};
	localparam int unsigned SLOT_GLOBAL_COMMAND = 0;
	localparam int unsigned SLOT_ROOT_TABLE_BASE = 1;
	localparam int unsigned SLOT_FAULT_STATE = 5;
	localparam int unsigned SLOT_PROTECTED_REGION_ENABLE = 12;
	localparam int unsigned SLOT_INVAL_QUEUE_TAIL = 19;
	localparam int unsigned SLOT_INVAL_QUEUE_BASE = 21;
	localparam int unsigned SLOT_INVAL_COMPLETION_STATE = 23;
	localparam int unsigned SLOT_IRQ_REMAP_TABLE_BASE = 28;
	localparam int unsigned SLOT_FAULT_RECORD = 34;
	localparam int unsigned FAULT_RECORD_DWORDS = 4;

	typedef struct packed {
		logic valid;
		logic write;
		logic qword;
		logic [11:0] addr;
		logic [63:0] wdata;
	} acc_req_t;

	typedef struct packed {
		logic done;
		logic [63:0] rdata;
	} acc_rsp_t;

	typedef struct packed {
		logic [31:0] global_command;
		logic [63:0] root_table_base;
		logic [31:0] protected_region_enable;
		logic [63:0] inval_queue_tail;
		logic [63:0] inval_queue_base;
		logic [63:0] irq_remap_table_base;
		logic [31:0] fault_state;
		logic [31:0] inval_completion_state;
	} remap_ctrl_t;

endpackage : remap_regs_pkg

// [remap_reg_cell.sv]
// one stored dword of the register bank with its access behaviour
module remap_reg_cell
	import remap_regs_pkg::*;
#(
	parameter cell_kind_t KIND = KIND_RW
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic sys_rst_i,
	input wire logic pwr_good_rst_i,
	input wire logic wr_en_i,
	input wire logic [31:0] wr_data_i,
	input wire logic [31:0] hw_set_i,
	input wire logic hw_load_i,
	input wire logic [31:0] hw_data_i,
	output logic [31:0] value_o
);

	logic sticky;
	logic [31:0] clear_bits;

	assign sticky = (KIND == KIND_W1CS) || (KIND == KIND_ROS);
	assign clear_bits = wr_en_i ? wr_data_i : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (pwr_good_rst_i) begin
			value_o <= 32'h00000000;
		end else if (sys_rst_i && !sticky) begin
			value_o <= 32'h00000000;
		end else if (ce_i) begin
			unique case (KIND)
				KIND_RW: begin
					if (wr_en_i) begin
						value_o <= wr_data_i;
					end
				end
				KIND_W1C: begin
					value_o <= (value_o & ~clear_bits) | hw_set_i;
				end
				KIND_W1CS: begin
					value_o <= (value_o & ~clear_bits) | hw_set_i;
				end
				KIND_ROS: begin
					if (hw_load_i) begin
						value_o <= hw_data_i;
					end
				end
			endcase
		end
	end

endmodule : remap_reg_cell

// [remap_unit_register_bank.sv]
// memory-mapped register page of the remapping unit
module remap_unit_register_bank
	import remap_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic sys_rst_i,
	input wire logic pwr_good_rst_i,
	input wire acc_req_t acc_i,
	input wire logic [31:0] global_state_i,
	input wire logic [63:0] queue_head_i,
	input wire logic [31:0] fault_set_i,
	input wire logic [31:0] compl_set_i,
	input wire logic fault_rec_load_i,
	input wire logic [127:0] fault_rec_i,
	output acc_rsp_t acc_o,
	output remap_ctrl_t ctrl_o
);

	logic take;
	logic take_wr;
	logic [IDX_W-1:0] lo_idx;
	logic [IDX_W-1:0] hi_idx;
	logic [31:0] slot_val [NSLOT];
	logic [31:0] slot_set [NSLOT];
	logic [31:0] slot_hw_data [NSLOT];
	logic slot_load [NSLOT];
	logic [31:0] rd_lo;
	logic [31:0] rd_hi;
	logic [31:0] global_state;
	logic [63:0] queue_head;

	// offset is within the 4KB-aligned page; the page decode lies upstream
	assign take = ce_i && acc_i.valid && !sys_rst_i && !pwr_good_rst_i;
	assign take_wr = take && acc_i.write;
	// quadwords are taken as an aligned pair of dwords
	assign lo_idx = acc_i.qword ? {acc_i.addr[11:3], 1'b0} : acc_i.addr[11:2];
	assign hi_idx = lo_idx | 10'h001;

	// hardware status sources
	always_comb begin
		for (int s = 0; s < NSLOT; s++) begin
			slot_set[s] = 32'h00000000;
			slot_hw_data[s] = 32'h00000000;
			slot_load[s] = 1'b0;
		end
		slot_set[SLOT_FAULT_STATE] = fault_set_i;
		slot_set[SLOT_INVAL_COMPLETION_STATE] = compl_set_i;
		for (int r = 0; r < FAULT_RECORD_DWORDS; r++) begin
			slot_load[SLOT_FAULT_RECORD + r] = fault_rec_load_i;
			slot_hw_data[SLOT_FAULT_RECORD + r] = fault_rec_i[32*r +: 32];
		end
		// the record's top dword holds its write-one-clear flags
		slot_set[SLOT_FAULT_RECORD + 3] = fault_rec_load_i ? fault_rec_i[127:96] : 32'h00000000;
	end

	// storage, one cell per stored dword
	for (genvar g = 0; g < NSLOT; g++) begin : gen_slot
		logic wr_lo;
		logic wr_hi;
		logic [31:0] wr_data;
		assign wr_lo = take_wr && (lo_idx == SLOT_ADDR[g][11:2]);
		assign wr_hi = take_wr && acc_i.qword && (hi_idx == SLOT_ADDR[g][11:2]);
		// both halves land in the same edge, each cell taking its own dword of the write data
		assign wr_data = wr_hi ? acc_i.wdata[63:32] : acc_i.wdata[31:0];
		remap_reg_cell #(
			.KIND(SLOT_KIND[g])
		) u_cell (
			.clk_i(clk_i),
			.ce_i(ce_i),
			.sys_rst_i(sys_rst_i),
			.pwr_good_rst_i(pwr_good_rst_i),
			.wr_en_i(wr_lo || wr_hi),
			.wr_data_i(wr_data),
			.hw_set_i(slot_set[g]),
			.hw_load_i(slot_load[g]),
			.hw_data_i(slot_hw_data[g]),
			.value_o(slot_val[g])
		);
	end

	// hardware-owned read-only registers, captured on each cycle with ce_i high
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || pwr_good_rst_i) begin
			global_state <= 32'h00000000;
			queue_head <= 64'h0000000000000000;
		end else if (ce_i) begin
			global_state <= global_state_i;
			queue_head <= queue_head_i;
		end
	end

	function automatic logic [31:0] read_dword(input logic [IDX_W-1:0] idx);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (idx)
			ADDR_VERSION[11:2]: v = VERSION_VALUE;
			ADDR_CAP[11:2]: v = CAP_VALUE[31:0];
			ADDR_CAP[11:2] + 10'h001: v = CAP_VALUE[63:32];
			ADDR_ECAP[11:2]: v = ECAP_VALUE[31:0];
			ADDR_ECAP[11:2] + 10'h001: v = ECAP_VALUE[63:32];
			ADDR_GLOBAL_STATE[11:2]: v = global_state;
			ADDR_INVAL_QUEUE_HEAD[11:2]: v = queue_head[31:0];
			ADDR_INVAL_QUEUE_HEAD[11:2] + 10'h001: v = queue_head[63:32];
			default: begin
				for (int s = 0; s < NSLOT; s++) begin
					if (idx == SLOT_ADDR[s][11:2]) begin
						v = slot_val[s];
					end
				end
			end
		endcase
		return v;
	endfunction : read_dword

	always_comb begin
		rd_lo = read_dword(lo_idx);
		rd_hi = acc_i.qword ? read_dword(hi_idx) : 32'h00000000;
	end

	// answer one cycle after the access is taken
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || pwr_good_rst_i) begin
			acc_o <= '0;
		end else if (ce_i) begin
			acc_o.done <= acc_i.valid;
			acc_o.rdata <= (acc_i.valid && !acc_i.write) ? {rd_hi, rd_lo} : 64'h0000000000000000;
		end
	end

	// control values to the rest of the unit
	always_comb begin
		ctrl_o.global_command = slot_val[SLOT_GLOBAL_COMMAND];
		ctrl_o.root_table_base = {slot_val[SLOT_ROOT_TABLE_BASE + 1], slot_val[SLOT_ROOT_TABLE_BASE]};
		ctrl_o.protected_region_enable = slot_val[SLOT_PROTECTED_REGION_ENABLE];
		ctrl_o.inval_queue_tail = {slot_val[SLOT_INVAL_QUEUE_TAIL + 1], slot_val[SLOT_INVAL_QUEUE_TAIL]};
		ctrl_o.inval_queue_base = {slot_val[SLOT_INVAL_QUEUE_BASE + 1], slot_val[SLOT_INVAL_QUEUE_BASE]};
		ctrl_o.irq_remap_table_base = {slot_val[SLOT_IRQ_REMAP_TABLE_BASE + 1],
			slot_val[SLOT_IRQ_REMAP_TABLE_BASE]};
		ctrl_o.fault_state = slot_val[SLOT_FAULT_STATE];
		ctrl_o.inval_completion_state = slot_val[SLOT_INVAL_COMPLETION_STATE];
	end

endmodule : remap_unit_register_bank

// [remap_unit_register_bank_notes_placeholder.sv]
// spare file of the register bank, holds no logic

// [remap_bank_chk_sva.sv]
// assertion checker for the remapping register page
module remap_bank_chk
	import remap_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic sys_rst_i,
	input wire logic pwr_good_rst_i,
	input wire acc_req_t acc_i,
	input wire logic [63:0] queue_head_i,
	input wire logic [31:0] fault_set_i,
	input wire logic [31:0] compl_set_i,
	input wire acc_rsp_t acc_o,
	input wire remap_ctrl_t ctrl_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tk;
	logic rd;
	logic wr;
	assign tk = ce_i && acc_i.valid;
	assign rd = tk && !acc_i.write;
	assign wr = tk && acc_i.write;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i || pwr_good_rst_i);
	property p_done; tk |=> acc_o.done; endproperty
	a_done: assert property (p_done) else $error("request without done");
	property p_ver; rd && acc_i.addr[11:2] == 10'h000 |=> acc_o.rdata == {32'h0, VERSION_VALUE}; endproperty
	a_ver: assert property (p_ver) else $error("bad version read");
	property p_cap; rd && acc_i.qword && acc_i.addr[11:3] == 9'h001 |=> acc_o.rdata == CAP_VALUE; endproperty
	a_cap: assert property (p_cap) else $error("bad capability read");
	property p_rsv; rd && !acc_i.qword && acc_i.addr[11:2] == 10'h001 |=> acc_o.rdata == 64'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved offset not zero");
	property p_root; wr && acc_i.qword && acc_i.addr[11:3] == 9'h004
		|=> ctrl_o.root_table_base == $past(acc_i.wdata); endproperty
	a_root: assert property (p_root) else $error("root table write lost");
	property p_cmd; wr && !acc_i.qword && acc_i.addr[11:2] == 10'h006
		|=> ctrl_o.global_command == $past(acc_i.wdata[31:0]); endproperty
	a_cmd: assert property (p_cmd) else $error("command write lost");
	property p_head; rd && acc_i.qword && acc_i.addr[11:3] == 9'h010
		|=> acc_o.rdata == $past(queue_head_i, 2); endproperty
	a_head: assert property (p_head) else $error("queue head read wrong");
	property p_w1c; wr && !acc_i.qword && acc_i.addr[11:2] == 10'h027 && compl_set_i == 32'h0
		|=> ctrl_o.inval_completion_state ==
		($past(ctrl_o.inval_completion_state) & ~$past(acc_i.wdata[31:0])); endproperty
	a_w1c: assert property (p_w1c) else $error("clear on write wrong");
	property p_sticky; disable iff (pwr_good_rst_i) sys_rst_i && fault_set_i == 32'h0
		|=> ctrl_o.fault_state == $past(ctrl_o.fault_state); endproperty
	a_sticky: assert property (p_sticky) else $error("sticky status lost");
endmodule : remap_bank_chk

bind remap_unit_register_bank remap_bank_chk chk_u (.clk_i(clk_i), .ce_i(ce_i),
	.sys_rst_i(sys_rst_i), .pwr_good_rst_i(pwr_good_rst_i), .acc_i(acc_i),
	.queue_head_i(queue_head_i), .fault_set_i(fault_set_i), .compl_set_i(compl_set_i),
	.acc_o(acc_o), .ctrl_o(ctrl_o));

// [test_remap_unit_register_bank.sv]
// self-checking bench of the remapping register page
module test_remap_unit_register_bank import remap_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic ce_i = 1'b1;
	logic sys_rst_i = 1'b1;
	logic pwr_good_rst_i = 1'b1;
	acc_req_t acc_i = '0;
	logic [31:0] global_state_i = 32'h0;
	logic [63:0] queue_head_i = 64'h0;
	logic [31:0] fault_set_i = 32'h0;
	logic [31:0] compl_set_i = 32'h0;
	logic fault_rec_load_i = 1'b0;
	logic [127:0] fault_rec_i = 128'h0;
	acc_rsp_t acc_o;
	remap_ctrl_t ctrl_o;
	logic [63:0] expq [$];
	logic [63:0] d;
	logic [11:0] rsv [7] = '{12'h004, 12'h030, 12'h048, 12'h060, 12'h098, 12'h0b0, 12'h300};
	int fails = 0;
	int tests_run = 0;
	always #50 clk_i = ~clk_i;
	remap_unit_register_bank dut_u (.clk_i(clk_i), .ce_i(ce_i), .sys_rst_i(sys_rst_i),
		.pwr_good_rst_i(pwr_good_rst_i), .acc_i(acc_i), .global_state_i(global_state_i),
		.queue_head_i(queue_head_i), .fault_set_i(fault_set_i), .compl_set_i(compl_set_i),
		.fault_rec_load_i(fault_rec_load_i), .fault_rec_i(fault_rec_i), .acc_o(acc_o),
		.ctrl_o(ctrl_o));
	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wrap_up;
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	// wq: bit 1 write, bit 0 quadword
	task acc(input logic [1:0] wq, input logic [11:0] a, input logic [63:0] wd, input logic [63:0] e);
		acc_i <= {1'b1, wq, a, wd};
		expq.push_back(e);
		@(negedge clk_i);
	endtask : acc
	task idle(input int n);
		acc_i.valid <= 1'b0;
		repeat (n) @(negedge clk_i);
	endtask : idle
	always @(negedge clk_i) begin
		if (acc_o.done === 1'b1) begin
			if (expq.size() > 0) begin
				check(acc_o.rdata, expq.pop_front());
			end else begin
				check({63'h0, acc_o.done}, 64'h0);
			end
		end
	end
	initial begin
		repeat (2000) @(posedge clk_i);
		fails++;
		wrap_up;
	end
	initial begin
		void'($urandom(34120));
		repeat (12) @(negedge clk_i);
		sys_rst_i <= 1'b0;
		pwr_good_rst_i <= 1'b0;
		@(negedge clk_i);
		acc(2'h0, ADDR_VERSION, 64'h0, {32'h0, VERSION_VALUE});
		acc(2'h1, ADDR_CAP, 64'h0, CAP_VALUE);
		acc(2'h1, ADDR_ECAP, 64'h0, ECAP_VALUE);
		foreach (rsv[i]) begin
			acc(2'h2, rsv[i], {$urandom, $urandom}, 64'h0);
			acc(2'h0, rsv[i], 64'h0, 64'h0);
		end
		for (int i = 0; i < NSLOT; i++) begin
			if (SLOT_KIND[i] == KIND_RW) begin
				d = {$urandom, $urandom};
				acc(2'h2, SLOT_ADDR[i], d, 64'h0);
				acc(2'h0, SLOT_ADDR[i], 64'h0, {32'h0, d[31:0]});
			end
		end
		d = {$urandom, $urandom};
		acc(2'h3, ADDR_ROOT_TABLE_BASE, d, 64'h0);
		acc(2'h1, ADDR_ROOT_TABLE_BASE, 64'h0, d);
		acc(2'h0, ADDR_ROOT_TABLE_BASE + 12'h004, 64'h0, {32'h0, d[63:32]});
		check(ctrl_o.root_table_base, d);
		acc(2'h2, ADDR_GLOBAL_COMMAND, 64'h5a, 64'h0);
		idle(1);
		ce_i <= 1'b0;
		acc_i <= {1'b1, 2'h2, ADDR_GLOBAL_COMMAND, 64'ha5};
		repeat (2) @(negedge clk_i);
		ce_i <= 1'b1;
		idle(1);
		check({32'h0, ctrl_o.global_command}, 64'h5a);
		acc(2'h0, ADDR_GLOBAL_COMMAND, 64'h0, 64'h5a);
		global_state_i <= $urandom;
		queue_head_i <= {$urandom, $urandom};
		idle(2);
		acc(2'h3, ADDR_INVAL_QUEUE_HEAD, ~queue_head_i, 64'h0);
		acc(2'h2, ADDR_GLOBAL_STATE, {32'h0, ~global_state_i}, 64'h0);
		acc(2'h2, ADDR_VERSION, 64'h000000ef, 64'h0);
		acc(2'h1, ADDR_INVAL_QUEUE_HEAD, 64'h0, queue_head_i);
		acc(2'h0, ADDR_GLOBAL_STATE, 64'h0, {32'h0, global_state_i});
		acc(2'h0, ADDR_VERSION, 64'h0, {32'h0, VERSION_VALUE});
		compl_set_i <= 32'h0000f00f;
		idle(1);
		compl_set_i <= 32'h0;
		acc(2'h2, ADDR_INVAL_COMPLETION_STATE, 64'h0ff1, 64'h0);
		acc(2'h0, ADDR_INVAL_COMPLETION_STATE, 64'h0, 64'hf00e);
		compl_set_i <= 32'h00000001;
		acc(2'h2, ADDR_INVAL_COMPLETION_STATE, 64'h1, 64'h0);
		compl_set_i <= 32'h0;
		acc(2'h0, ADDR_INVAL_COMPLETION_STATE, 64'h0, 64'hf00f);
		check({32'h0, ctrl_o.inval_completion_state}, 64'hf00f);
		fault_set_i <= 32'h80000001;
		fault_rec_i <= {$urandom, $urandom, $urandom, $urandom};
		fault_rec_load_i <= 1'b1;
		idle(1);
		fault_set_i <= 32'h0;
		fault_rec_load_i <= 1'b0;
		sys_rst_i <= 1'b1;
		idle(2);
		sys_rst_i <= 1'b0;
		idle(1);
		check({32'h0, ctrl_o.fault_state}, 64'h80000001);
		acc(2'h3, ADDR_FAULT_RECORD, 64'hffffffffffffffff, 64'h0);
		acc(2'h1, ADDR_FAULT_RECORD, 64'h0, fault_rec_i[63:0]);
		acc(2'h1, ADDR_FAULT_RECORD + 12'h008, 64'h0, fault_rec_i[127:64]);
		acc(2'h0, ADDR_FAULT_STATE, 64'h0, 64'h80000001);
		acc(2'h2, ADDR_FAULT_STATE, 64'h1, 64'h0);
		acc(2'h0, ADDR_FAULT_STATE, 64'h0, 64'h80000000);
		pwr_good_rst_i <= 1'b1;
		idle(2);
		pwr_good_rst_i <= 1'b0;
		idle(1);
		acc(2'h0, ADDR_FAULT_STATE, 64'h0, 64'h0);
		acc(2'h1, ADDR_FAULT_RECORD, 64'h0, 64'h0);
		acc(2'h1, ADDR_FAULT_RECORD + 12'h008, 64'h0, 64'h0);
		idle(2);
		check(64'(expq.size()), 64'h0);
		wrap_up;
	end
endmodule : test_remap_unit_register_bank
